// ==== bench/rgc_ctrl_properties.sv ====
`timescale 1ns/10ps
module rgc_ctrl_properties #(
  parameter int POR_CYCLES = 20,
  parameter int DLY_UNIT = 10,
  parameter int MEAS_CYCLES = 2500
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register bus
  input wire rgc_pkg::rgc_wb_req_t wb_req_i,
  input wire rgc_pkg::rgc_wb_rsp_t wb_rsp_o,
  // pins and analog side
  input wire logic supply_ok_i,
  input wire logic en_pin_i,
  input wire logic sync_clock_input,
  input wire logic [1:0] buck_heavy_load_i,
  input wire logic [8:0] meas_code_i,
  // regulator controls
  input wire rgc_pkg::rgc_out_t ctl_o,
  input wire logic irq_o
);
  logic prev_q;
  logic [9:0] idle_q;
  // cycles since the last sync edge, saturating
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q <= 1'b0;
      idle_q <= 10'h0;
    end else begin
      prev_q <= sync_clock_input;
      idle_q <= (sync_clock_input != prev_q) ? 10'h0 : idle_q + 10'(idle_q != 10'h3ff);
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence heavy0_s;
    buck_heavy_load_i[0] [*3];
  endsequence
  sequence load_hi_rd_s;
    wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && wb_req_i.adr == rgc_pkg::ADDR_LOAD2 ##1 wb_rsp_o.ack;
  endsequence
  ack_one_cycle_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held too long");
  load_msb_only_a: assert property (load_hi_rd_s |-> wb_rsp_o.dat[31:1] == 31'h0)
    else $error("result high register wider than one bit");
  spread_rc_only_a: assert property (!(ctl_o.spread_on && ctl_o.ext_clk_sel))
    else $error("spread with external clock");
  heavy_load_pwm_a: assert property (heavy0_s |-> ctl_o.buck_pwm[0]) else $error("no pwm at heavy load");
  rise_has_cause_a: assert property ($rose(ctl_o.buck_on[0]) |-> en_pin_i || wb_rsp_o.ack ||
    $past(wb_rsp_o.ack) || $past(wb_rsp_o.ack, 2)) else $error("buck started without cause");
  fall_has_cause_a: assert property ($fell(ctl_o.buck_on[0]) |-> !en_pin_i || wb_rsp_o.ack ||
    $past(wb_rsp_o.ack) || $past(wb_rsp_o.ack, 2)) else $error("buck stopped without cause");
  irq_clear_write_a: assert property ($fell(irq_o) |-> wb_rsp_o.ack || $past(wb_rsp_o.ack) ||
    $past(wb_rsp_o.ack, 2)) else $error("irq dropped without write");
  ext_clock_lost_a: assert property (idle_q >= 10'd600 |-> !ctl_o.ext_clk_sel)
    else $error("dead clock still selected");
endmodule // rgc_ctrl_properties
bind rgc_ctrl rgc_ctrl_properties #(.POR_CYCLES(POR_CYCLES), .DLY_UNIT(DLY_UNIT), .MEAS_CYCLES(MEAS_CYCLES)) u_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .supply_ok_i(supply_ok_i),
  .en_pin_i(en_pin_i), .sync_clock_input(sync_clock_input), .buck_heavy_load_i(buck_heavy_load_i),
  .meas_code_i(meas_code_i), .ctl_o(ctl_o), .irq_o(irq_o));

// ==== bench/rgc_far_model.sv ====
`timescale 1ns/10ps
module rgc_far_model #(
  parameter int LOAD_MA = 8420
) (
  // clock and control
  input wire logic mclk_i,
  input wire logic clk_run_i,
  // analog side
  output logic sync_clock_input,
  output logic [8:0] meas_code_o
);
  logic [2:0] div_q = 3'h0;
  // 5 mhz, well under the sampling limit; stands low when stopped
  always_ff @(posedge mclk_i) begin
    div_q <= (!clk_run_i || div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    sync_clock_input <= clk_run_i && (sync_clock_input ^ (div_q == 3'h4));
  end
  assign meas_code_o = 9'(LOAD_MA / rgc_pkg::LSB_MA);
endmodule // rgc_far_model

// ==== bench/test_regulator_enable_and_clock_control.sv ====
`timescale 1ns/10ps
module test_regulator_enable_and_clock_control;
  localparam int LOAD_MA = 8420;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic supply_ok = 1'b0;
  logic en_pin = 1'b0;
  logic clk_run = 1'b0;
  logic [1:0] heavy = 2'h0;
  logic sync_clk;
  logic [8:0] meas_code;
  logic irq;
  logic [31:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  rgc_pkg::rgc_wb_req_t req = '0;
  rgc_pkg::rgc_wb_rsp_t rsp;
  rgc_pkg::rgc_out_t ctl;
  rgc_ctrl #(.POR_CYCLES(20), .DLY_UNIT(10), .MEAS_CYCLES(2500)) dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .supply_ok_i(supply_ok), .en_pin_i(en_pin), .sync_clock_input(sync_clk),
    .buck_heavy_load_i(heavy), .meas_code_i(meas_code), .ctl_o(ctl), .irq_o(irq));
  rgc_far_model #(.LOAD_MA(LOAD_MA)) far_u (.mclk_i(mclk_i), .clk_run_i(clk_run), .sync_clock_input(sync_clk),
    .meas_code_o(meas_code));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // request held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    @(posedge mclk_i);
    while (rsp.ack !== 1'b1) @(posedge mclk_i);
    rd = rsp.dat;
    req <= '0;
  endtask
  task automatic t_reset();
    @(posedge mclk_i);
    supply_ok <= 1'b1;
    cyc(40); // host waits out the power-on load
    chk("out", 32'(ctl), 32'h0);
    wb(1'b0, rgc_pkg::ADDR_CLK_CFG, 32'h0);
    chk("clk dflt", rd, 32'(rgc_pkg::DFLT_CLK));
    wb(1'b1, rgc_pkg::ADDR_BUCK_DLY, 32'h0000_0012);
    wb(1'b0, rgc_pkg::ADDR_BUCK_DLY, 32'h0);
    chk("dly rw", rd, 32'h0000_0012);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_reg_en();
    wb(1'b1, rgc_pkg::ADDR_ENABLE, 32'h33);
    cyc(3);
    chk("reg buck", 32'(ctl.buck_on), 32'h3);
    chk("reg lin", 32'(ctl.linear_on), 32'h3);
    wb(1'b1, rgc_pkg::ADDR_ENABLE, 32'h0);
    cyc(3);
    chk("reg off", 32'(ctl.buck_on), 32'h0);
  endtask
  task automatic t_pin();
    wb(1'b1, rgc_pkg::ADDR_LIN_DLY, 32'h0000_0031);
    wb(1'b1, rgc_pkg::ADDR_ENABLE, 32'h55);
    cyc(3);
    chk("pin low", 32'(ctl.buck_on), 32'h0);
    @(posedge mclk_i);
    en_pin <= 1'b1;
    cyc(15);
    chk("rise b", 32'(ctl.buck_on), 32'h0);
    chk("rise l", 32'(ctl.linear_on), 32'h1);
    cyc(10);
    chk("rise b2", 32'(ctl.buck_on), 32'h1);
    @(posedge mclk_i);
    en_pin <= 1'b0;
    cyc(5);
    chk("fall b", 32'(ctl.buck_on), 32'h1);
    cyc(10);
    chk("fall b2", 32'(ctl.buck_on), 32'h0);
    chk("fall l", 32'(ctl.linear_on), 32'h1);
    cyc(25);
    chk("fall l2", 32'(ctl.linear_on), 32'h0);
    wb(1'b1, rgc_pkg::ADDR_ENABLE, 32'h0);
  endtask
  task automatic t_meas(input logic sel, input logic mask);
    wb(1'b1, rgc_pkg::ADDR_MASK, 32'(mask));
    wb(1'b1, rgc_pkg::ADDR_MEAS_SEL, 32'(sel));
    cyc(3);
    chk("meas pwm", 32'(ctl.buck_pwm), 32'(1 << sel));
    wb(1'b0, rgc_pkg::ADDR_MEAS_SEL, 32'h0);
    chk("busy", 32'(rd[1]), 32'h1);
    cyc(2500);
    chk("meas end", 32'(ctl.buck_pwm), 32'h0);
    wb(1'b0, rgc_pkg::ADDR_STATUS, 32'h0);
    chk("flags", 32'(rd[1:0]), 32'(!mask));
    chk("irq", 32'(irq), 32'(!mask));
    wb(1'b0, rgc_pkg::ADDR_LOAD1, 32'h0);
    chk("res lo", rd, 32'(LOAD_MA / rgc_pkg::LSB_MA) & 32'hff);
    wb(1'b0, rgc_pkg::ADDR_LOAD2, 32'h0);
    chk("res hi", rd, 32'((LOAD_MA / rgc_pkg::LSB_MA) >> 8));
    wb(1'b1, rgc_pkg::ADDR_STATUS, 32'h3);
    cyc(2);
    chk("irq clr", 32'(irq), 32'h0);
  endtask
  task automatic t_mode();
    @(posedge mclk_i);
    heavy <= 2'h1;
    cyc(4);
    chk("auto pwm", 32'(ctl.buck_pwm), 32'h1);
    @(posedge mclk_i);
    heavy <= 2'h0;
    cyc(4);
    chk("auto pfm", 32'(ctl.buck_pwm), 32'h0);
    wb(1'b1, rgc_pkg::ADDR_CLK_CFG, 32'h0002_0002);
    cyc(3);
    chk("forced", 32'(ctl.buck_pwm), 32'h2);
    chk("spread", 32'(ctl.spread_on), 32'h1);
    wb(1'b1, rgc_pkg::ADDR_CLK_CFG, 32'h0000_0003);
    cyc(3);
    chk("spread pll", 32'(ctl.spread_on), 32'h0);
  endtask
  task automatic t_sync(input logic [31:0] cfg, input logic on, input logic [31:0] sel, input logic [31:0] st);
    wb(1'b1, rgc_pkg::ADDR_CLK_CFG, cfg); // nominal code from 1 to 24
    wb(1'b1, rgc_pkg::ADDR_STATUS, 32'h3);
    @(posedge mclk_i);
    clk_run <= on;
    cyc(700);
    chk("ext sel", 32'(ctl.ext_clk_sel), sel);
    wb(1'b0, rgc_pkg::ADDR_STATUS, 32'h0);
    chk("sync flags", 32'(rd[2:1]), st);
  endtask
  initial begin
    @(negedge mclk_i);
    chk("rst out", 32'(ctl), 32'h0);
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_reg_en();
    t_pin();
    t_meas(1'b1, 1'b0);
    t_meas(1'b0, 1'b1);
    t_mode();
    t_sync(32'h0501, 1'b1, 32'h1, 32'h3);
    t_sync(32'h0501, 1'b0, 32'h0, 32'h1);
    wb(1'b1, rgc_pkg::ADDR_MASK, 32'h2);
    t_sync(32'h0a01, 1'b1, 32'h0, 32'h0);
    t_sync(32'h0a01, 1'b0, 32'h0, 32'h0);
    wb(1'b1, rgc_pkg::ADDR_MASK, 32'h0);
    wb(1'b1, rgc_pkg::ADDR_ENABLE, 32'h1);
    cyc(5);
    wb(1'b0, rgc_pkg::ADDR_STATUS, 32'h0);
    chk("clk missing", 32'(rd[1]), 32'h1);
    give_verdict();
  end
endmodule // test_regulator_enable_and_clock_control

// ==== core/rgc_ctrl.sv ====
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
module rgc_ctrl #(
  parameter int POR_CYCLES = rgc_pkg::POR_CYC,
  parameter int DLY_UNIT = 50000,
  parameter int MEAS_CYCLES = rgc_pkg::MEAS_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register bus
  input wire rgc_pkg::rgc_wb_req_t wb_req_i,
  output rgc_pkg::rgc_wb_rsp_t wb_rsp_o,
  // pins and analog side
  input wire logic supply_ok_i,
  input wire logic en_pin_i,
  input wire logic sync_clock_input,
  input wire logic [1:0] buck_heavy_load_i,
  input wire logic [8:0] meas_code_i,
  // regulator controls
  output rgc_pkg::rgc_out_t ctl_o,
  output logic irq_o
);
  localparam int DW = 24;
  localparam int MW = 13;
  localparam int WW = 8;

  // counters are sized for the defaults; refuse anything that would wrap
  if (POR_CYCLES < 1 || POR_CYCLES >= (1 << DW) || MEAS_CYCLES < 2 || MEAS_CYCLES >= (1 << MW)
      || DLY_UNIT < 1 || DLY_UNIT * 16 >= (1 << DW)) begin : g_bad_param
    $error("rgc_ctrl: parameter out of range");
  end

  typedef struct packed {
    rgc_pkg::rgc_mode_t mode;
    logic [DW-1:0] por_cnt;
    logic [7:0] enable;        // [1:0] buck_on_bit [3:2] buck_pin_follow [5:4] linear [7:6] linear follow
    logic [15:0] buck_dly;     // per buck: rise code [3:0], fall code [7:4]
    logic [15:0] lin_dly;
    logic [15:0] clk_cfg;
    logic [1:0] fpwm;
    logic [1:0] mask;
    logic [1:0] flags;
    rgc_pkg::rgc_meas_t ms;
    logic meas_sel;
    logic [MW-1:0] meas_cnt;
    logic [8:0] result;
    logic pin_q;
    logic [3:0] reg_on;
    logic [3:0][DW-1:0] dly_cnt;
    logic [WW-1:0] ext_cnt;
    logic [DW-1:0] win_cnt;
    logic ext_prev;
    logic ext_valid;
    logic wb_ack;
    logic [31:0] wb_dat;
    rgc_pkg::rgc_out_t out;
    logic irq;
  } st_t;

  st_t s_q, s_d;

  // delay code to cycles, table linear in code
  function automatic logic [DW-1:0] dly_cycles(input logic [3:0] code);
    dly_cycles = DW'(DLY_UNIT) * DW'(code);
  endfunction

  function automatic logic bus_hit(input rgc_pkg::rgc_wb_req_t r, input logic [7:0] a);
    bus_hit = r.cyc && r.stb && (r.adr == a);
  endfunction

  logic [3:0] on_bit, follow;
  logic [3:0][3:0] rise_code, fall_code;
  logic [WW-1:0] lo_lim, hi_lim;
  logic [4:0] nom;
  logic ext_rise;

  always_comb begin
    on_bit = {s_q.enable[5:4], s_q.enable[1:0]};
    follow = {s_q.enable[7:6], s_q.enable[3:2]};
    rise_code = {s_q.lin_dly[11:8], s_q.lin_dly[3:0], s_q.buck_dly[11:8], s_q.buck_dly[3:0]};
    fall_code = {s_q.lin_dly[15:12], s_q.lin_dly[7:4], s_q.buck_dly[15:12], s_q.buck_dly[7:4]};
    nom = s_q.clk_cfg[rgc_pkg::POS_FREQ +: 5];
    // edges per 4 us window is 4*nom MHz; bounds scaled by percentage
    lo_lim = WW'((32'(nom) * rgc_pkg::WIN_US * rgc_pkg::LO_PCT) / 100);
    hi_lim = WW'((32'(nom) * rgc_pkg::WIN_US * rgc_pkg::HI_PCT) / 100);
    ext_rise = sync_clock_input && !s_q.ext_prev;
  end

  always_comb begin
    logic wr, rd, sync_ev, buck_en_rise, valid_new;
    logic [31:0] rdata;
    logic [1:0] set_flags;
    s_d = s_q;
    wr = 1'b0;
    rd = 1'b0;
    sync_ev = 1'b0;
    buck_en_rise = 1'b0;
    valid_new = s_q.ext_valid;
    rdata = 32'h0000_0000;
    set_flags = 2'h0;
    s_d.wb_ack = 1'b0;
    s_d.pin_q = en_pin_i;
    s_d.ext_prev = sync_clock_input;

    // power-up sequence
    case (s_q.mode)
      rgc_pkg::ST_POR: begin
        if (supply_ok_i) begin
          s_d.mode = rgc_pkg::ST_OTP;
        end
      end
      rgc_pkg::ST_OTP: begin
        // bus held off until defaults are in
        if (s_q.por_cnt == DW'(POR_CYCLES - 1)) begin
          s_d.enable = rgc_pkg::DFLT_ENABLE;
          s_d.buck_dly = rgc_pkg::DFLT_DLY[15:0];
          s_d.lin_dly = rgc_pkg::DFLT_DLY[31:16];
          s_d.clk_cfg = rgc_pkg::DFLT_CLK;
          s_d.mask = rgc_pkg::DFLT_MASK;
          s_d.mode = rgc_pkg::ST_STANDBY;
          if (rgc_pkg::DFLT_CLK[rgc_pkg::POS_PLL] && !s_q.ext_valid) begin
            sync_ev = 1'b1;
          end
        end else begin
          s_d.por_cnt = s_q.por_cnt + DW'(1);
        end
      end
      rgc_pkg::ST_STANDBY, rgc_pkg::ST_ACTIVE: begin
        s_d.mode = (|s_q.reg_on[1:0]) ? rgc_pkg::ST_ACTIVE : rgc_pkg::ST_STANDBY;
      end
      default: s_d.mode = rgc_pkg::ST_POR;
    endcase
    if (!supply_ok_i) begin
      s_d.mode = rgc_pkg::ST_POR;
      s_d.por_cnt = '0;
    end

    // wishbone slave, one wait state, only after defaults loaded
    if (wb_req_i.cyc && wb_req_i.stb && !s_q.wb_ack
        && (s_q.mode == rgc_pkg::ST_STANDBY || s_q.mode == rgc_pkg::ST_ACTIVE)) begin
      s_d.wb_ack = 1'b1;
      wr = wb_req_i.we && wb_req_i.sel[0];
      rd = !wb_req_i.we;
    end
    case (wb_req_i.adr)
      rgc_pkg::ADDR_ENABLE: rdata = {24'h000000, s_q.enable};
      rgc_pkg::ADDR_BUCK_DLY: rdata = {16'h0000, s_q.buck_dly};
      rgc_pkg::ADDR_LIN_DLY: rdata = {16'h0000, s_q.lin_dly};
      rgc_pkg::ADDR_CLK_CFG: rdata = {14'h0000, s_q.fpwm, s_q.clk_cfg};
      rgc_pkg::ADDR_MEAS_SEL: rdata = {30'h00000000, s_q.ms == rgc_pkg::MS_RUN, s_q.meas_sel};
      rgc_pkg::ADDR_LOAD1: rdata = {24'h000000, s_q.result[7:0]};
      rgc_pkg::ADDR_LOAD2: rdata = {31'h00000000, s_q.result[8]};
      rgc_pkg::ADDR_STATUS: rdata = {29'h00000000, s_q.ext_valid, s_q.flags};
      rgc_pkg::ADDR_MASK: rdata = {30'h00000000, s_q.mask};
      rgc_pkg::ADDR_OUT: rdata = {24'h000000, s_q.out};
      default: rdata = 32'h0000_0000;
    endcase
    if (rd) begin
      s_d.wb_dat = rdata;
    end
    if (wr) begin
      case (wb_req_i.adr)
        rgc_pkg::ADDR_ENABLE: s_d.enable = wb_req_i.dat[7:0];
        rgc_pkg::ADDR_BUCK_DLY: s_d.buck_dly = wb_req_i.dat[15:0];
        rgc_pkg::ADDR_LIN_DLY: s_d.lin_dly = wb_req_i.dat[15:0];
        rgc_pkg::ADDR_CLK_CFG: begin
          s_d.clk_cfg = wb_req_i.dat[15:0];
          s_d.fpwm = wb_req_i.dat[17:16];
        end
        rgc_pkg::ADDR_MEAS_SEL: begin
          s_d.meas_sel = wb_req_i.dat[0];
          s_d.ms = rgc_pkg::MS_RUN;
          s_d.meas_cnt = '0;
        end
        rgc_pkg::ADDR_MASK: s_d.mask = wb_req_i.dat[1:0];
        default: ;
      endcase
    end

    // regulator enables: pin path delayed, register path immediate
    for (int i = 0; i < 4; i++) begin
      if (s_q.mode != rgc_pkg::ST_STANDBY && s_q.mode != rgc_pkg::ST_ACTIVE) begin
        s_d.reg_on[i] = 1'b0;
        s_d.dly_cnt[i] = '0;
      end else if (!on_bit[i]) begin
        s_d.reg_on[i] = 1'b0;
        s_d.dly_cnt[i] = '0;
      end else if (!follow[i]) begin
        s_d.reg_on[i] = 1'b1;
        s_d.dly_cnt[i] = '0;
      end else if (en_pin_i != s_q.pin_q) begin
        s_d.dly_cnt[i] = en_pin_i ? dly_cycles(rise_code[i]) : dly_cycles(fall_code[i]);
        if (s_d.dly_cnt[i] == '0) begin
          s_d.reg_on[i] = en_pin_i;
        end
      end else if (s_q.dly_cnt[i] != '0) begin
        s_d.dly_cnt[i] = s_q.dly_cnt[i] - DW'(1);
        if (s_q.dly_cnt[i] == DW'(1)) begin
          s_d.reg_on[i] = s_q.pin_q;
        end
      end else begin
        s_d.reg_on[i] = s_q.pin_q;
      end
      if (i < 2 && s_d.reg_on[i] && !s_q.reg_on[i]) begin
        buck_en_rise = 1'b1;
      end
    end
    if (buck_en_rise && s_q.mode == rgc_pkg::ST_STANDBY && s_q.clk_cfg[rgc_pkg::POS_PLL] && !s_q.ext_valid) begin
      sync_ev = 1'b1;
    end

    // load-current measurement
    case (s_q.ms)
      rgc_pkg::MS_IDLE: ;
      rgc_pkg::MS_RUN: begin
        if (!(wr && wb_req_i.adr == rgc_pkg::ADDR_MEAS_SEL)) begin
          s_d.meas_cnt = s_q.meas_cnt + MW'(1);
          if (s_q.meas_cnt == MW'(MEAS_CYCLES - 1)) begin
            s_d.ms = rgc_pkg::MS_IDLE;
            s_d.result = meas_code_i;
            set_flags[rgc_pkg::BIT_MEAS] = !s_q.mask[rgc_pkg::BIT_MEAS];
          end
        end
      end
      default: s_d.ms = rgc_pkg::MS_IDLE;
    endcase

    // external clock frequency check over fixed windows
    s_d.ext_cnt = s_q.ext_cnt + WW'(ext_rise && s_q.ext_cnt != '1);
    s_d.win_cnt = s_q.win_cnt + DW'(1);
    if (s_q.win_cnt == DW'(rgc_pkg::WIN_CYC - 1)) begin
      s_d.win_cnt = '0;
      s_d.ext_cnt = '0;
      valid_new = (nom != 5'h00) && (s_q.ext_cnt >= lo_lim) && (s_q.ext_cnt <= hi_lim);
      s_d.ext_valid = valid_new;
      if (valid_new != s_q.ext_valid && s_q.clk_cfg[rgc_pkg::POS_PLL]) begin
        sync_ev = 1'b1;
      end
    end
    if (sync_ev && !s_q.mask[rgc_pkg::BIT_SYNC]) begin
      set_flags[rgc_pkg::BIT_SYNC] = 1'b1;
    end
    // write one to clear; a set in the same cycle wins
    if (wr && wb_req_i.adr == rgc_pkg::ADDR_STATUS) begin
      s_d.flags = s_q.flags & ~wb_req_i.dat[1:0];
    end
    s_d.flags = s_d.flags | set_flags;
    s_d.irq = |s_d.flags;

    // converter outputs
    for (int b = 0; b < 2; b++) begin
      s_d.out.buck_pwm[b] = s_q.fpwm[b]
        || (buck_heavy_load_i[b])
        || (s_q.ms == rgc_pkg::MS_RUN && s_q.meas_sel == b[0]);
    end
    s_d.out.buck_on = s_q.reg_on[1:0];
    s_d.out.linear_on = s_q.reg_on[3:2];
    s_d.out.spread_on = s_q.clk_cfg[rgc_pkg::POS_SPREAD] && !s_q.clk_cfg[rgc_pkg::POS_PLL];
    s_d.out.ext_clk_sel = s_q.clk_cfg[rgc_pkg::POS_PLL] && s_q.ext_valid;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp_o.ack = s_q.wb_ack;
  assign wb_rsp_o.dat = s_q.wb_dat;
  assign ctl_o = s_q.out;
  assign irq_o = s_q.irq;
endmodule // rgc_ctrl

// ==== core/rgc_pkg.sv ====
package rgc_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_BUCK_DLY = 8'h04;
  localparam logic [7:0] ADDR_LIN_DLY = 8'h08;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h0c;
  localparam logic [7:0] ADDR_MEAS_SEL = 8'h10;
  localparam logic [7:0] ADDR_LOAD1 = 8'h14;
  localparam logic [7:0] ADDR_LOAD2 = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_OUT = 8'h24;
  // status / mask bit positions
  localparam int BIT_MEAS = 0;
  localparam int BIT_SYNC = 1;
  // clock config fields
  localparam int POS_PLL = 0;
  localparam int POS_SPREAD = 1;
  localparam int POS_FREQ = 8;
  // mode threshold and scale
  localparam int THRESH_MA = 600;
  localparam int LSB_MA = 20;
  localparam logic [8:0] PWM_THRESH_CODE = 9'(THRESH_MA / LSB_MA);
  // timing
  localparam int CLK_MHZ = 50;
  localparam int MEAS_US = 50;
  localparam int MEAS_CYC = MEAS_US * CLK_MHZ;
  localparam int POR_US = 1200;
  localparam int POR_CYC = POR_US * CLK_MHZ;
  localparam int WIN_US = 4;
  localparam int WIN_CYC = WIN_US * CLK_MHZ;
  // ext clock window: -30% .. +10% of nominal, counts per window
  localparam int LO_PCT = 70;
  localparam int HI_PCT = 110;
  // reset defaults loaded from one-time memory
  localparam logic [7:0] DFLT_ENABLE = 8'h00;
  localparam logic [31:0] DFLT_DLY = 32'h0000_0000;
  localparam logic [15:0] DFLT_CLK = 16'h0000;
  localparam logic [1:0] DFLT_MASK = 2'h0;

  typedef enum {ST_POR, ST_OTP, ST_STANDBY, ST_ACTIVE} rgc_mode_t;
  typedef enum {MS_IDLE, MS_RUN} rgc_meas_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rgc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rgc_wb_rsp_t;

  typedef struct packed {
    logic [1:0] buck_on;
    logic [1:0] linear_on;
    logic [1:0] buck_pwm;
    logic spread_on;
    logic ext_clk_sel;
  } rgc_out_t;
endpackage
